// *** pkg/wdt_pkg.sv ***
package wdt_pkg;
  // register map (byte addresses, low eight address bits decoded)
  localparam logic [7:0] ADDR_OPTION  = 8'hC0;
  localparam logic [7:0] ADDR_SERVICE = 8'hC4;
  localparam logic [7:0] ADDR_STATUS  = 8'hC8;
  localparam logic [7:0] ADDR_MASK    = 8'hCC;
  localparam logic [7:0] ADDR_COUNT   = 8'hD0;

  // option byte field positions
  localparam int OPT_STANDBY_BIT = 0;
  localparam int OPT_OVF_LSB     = 1;
  localparam int OPT_ENABLE_BIT  = 4;
  localparam int OPT_WIN_LSB     = 5;

  // window selection codes
  localparam logic [1:0] WIN_50  = 2'h1;
  localparam logic [1:0] WIN_75  = 2'h2;
  localparam logic [1:0] WIN_100 = 2'h3;

  localparam logic [7:0] SERVICE_KEY = 8'hAC;
  localparam int         CNT_W       = 17;
  localparam logic [16:0] CNT_ONE    = 17'h00001;

  // overflow exponent of the low-speed clock, indexed by the selection field
  localparam logic [4:0] OVF_SHIFT [8] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0B, 5'h0D, 5'h0E, 5'h10};

  // status / mask bit positions
  localparam int STAT_W      = 3;
  localparam int ST_INTERVAL = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_SERVICE  = 2;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // edges after reset release before the synchronised option byte is valid
  localparam logic [1:0] LOAD_DELAY = 2'h2;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] OPT_RESET  = 8'h00;

  typedef struct packed {
    logic [2:0] ovf_sel;
    logic [1:0] win_sel;
    logic       enable;
    logic       standby_run;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{ovf_sel: 3'h0, win_sel: 2'h0, enable: 1'b0, standby_run: 1'b0};
endpackage

// *** verilog/wdt_sync.sv ***
`timescale 1ns/10ps
module wdt_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule

// *** verilog/windowed_watchdog_timer.sv ***
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module windowed_watchdog_timer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [7:0]  i_option_byte,
  input  wire logic        i_low_speed_osc_clock,
  input  wire logic        i_standby,
  output logic             o_wdt_reset,
  output logic             o_irq
);
  logic [7:0]              opt_sync;
  logic [1:0]              pin_sync;
  logic                    osc_prev_reg;
  logic [1:0]              load_cnt_reg;
  logic                    loaded_reg;
  logic [7:0]              opt_reg;
  wdt_pkg::cfg_s           cfg;
  logic                    wr_pend_reg;
  logic [7:0]              wr_addr_reg;
  logic [2:0]              wr_size_reg;
  logic [wdt_pkg::CNT_W-1:0] cnt_reg;
  logic [wdt_pkg::CNT_W-1:0] period;
  logic [wdt_pkg::CNT_W-1:0] ovf_max;
  logic [wdt_pkg::CNT_W-1:0] open_start;
  logic [wdt_pkg::CNT_W-1:0] three_q;
  logic [wdt_pkg::STAT_W-1:0] stat_reg;
  logic [wdt_pkg::STAT_W-1:0] stat_next;
  logic [wdt_pkg::STAT_W-1:0] mask_reg;
  logic [31:0]             rdata_next;
  logic                    osc_rise;
  logic                    osc_fall;
  logic                    run;
  logic                    win_open;
  logic                    addr_valid;
  logic                    svc_write;
  logic                    svc_ok;
  logic                    svc_bad;
  logic                    ovf_evt;
  logic                    interval_evt;

  wdt_sync #(.W(8)) opt_sync_u (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_option_byte),
    .o_sync    (opt_sync)
  );

  wdt_sync #(.W(2)) pin_sync_u (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   ({i_standby, i_low_speed_osc_clock}),
    .o_sync    (pin_sync)
  );

  assign osc_rise = pin_sync[0] & ~osc_prev_reg;
  assign osc_fall = ~pin_sync[0] & osc_prev_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= pin_sync[0];
    end
  end

  // capture waits out the synchroniser so a stale zero is never latched
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      load_cnt_reg <= 2'h0;
      loaded_reg   <= 1'b0;
      opt_reg      <= wdt_pkg::OPT_RESET;
    end else if (!loaded_reg) begin
      if (load_cnt_reg == wdt_pkg::LOAD_DELAY) begin
        loaded_reg <= 1'b1;
        opt_reg    <= opt_sync;
      end else begin
        load_cnt_reg <= load_cnt_reg + 2'h1;
      end
    end
  end

  // one process drives the whole struct, so it has a single driver
  always_comb begin
    cfg.ovf_sel     = opt_reg[wdt_pkg::OPT_OVF_LSB +: 3];
    cfg.win_sel     = opt_reg[wdt_pkg::OPT_WIN_LSB +: 2];
    cfg.enable      = opt_reg[wdt_pkg::OPT_ENABLE_BIT];
    cfg.standby_run = opt_reg[wdt_pkg::OPT_STANDBY_BIT];
  end

  assign period  = wdt_pkg::CNT_ONE << wdt_pkg::OVF_SHIFT[cfg.ovf_sel];
  assign ovf_max = period - wdt_pkg::CNT_ONE;
  assign three_q = period - (period >> 2);

  always_comb begin
    open_start = '0;
    if (cfg.standby_run) begin
      unique case (cfg.win_sel)
        wdt_pkg::WIN_75:  open_start = period >> 2;
        wdt_pkg::WIN_100: open_start = '0;
        default:          open_start = period >> 1;
      endcase
    end
  end

  assign win_open = cnt_reg >= open_start;
  assign run      = loaded_reg & cfg.enable & (cfg.standby_run | ~pin_sync[1]);

  // zero-wait slave: address phase captured, write data used one cycle later
  assign addr_valid  = i_hsel & i_hready & i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_size_reg <= 3'h0;
    end else begin
      wr_pend_reg <= addr_valid & i_hwrite;
      wr_addr_reg <= i_haddr[7:0];
      wr_size_reg <= i_hsize;
    end
  end

  assign svc_write = wr_pend_reg & (wr_addr_reg == wdt_pkg::ADDR_SERVICE) & loaded_reg & cfg.enable;
  assign svc_ok    = svc_write & win_open & (wr_size_reg == wdt_pkg::HSIZE_WORD)
                     & (i_hwdata[7:0] == wdt_pkg::SERVICE_KEY);
  assign svc_bad   = svc_write & ~svc_ok;
  assign ovf_evt   = run & osc_rise & (cnt_reg == ovf_max);
  // half a slow tick past the three-quarter count lands on the falling edge
  assign interval_evt = run & osc_fall & (cnt_reg == three_q);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !cfg.enable) begin
      cnt_reg <= '0;
    end else if (svc_write || ovf_evt) begin
      cnt_reg <= '0;
    end else if (run && osc_rise) begin
      cnt_reg <= cnt_reg + wdt_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_wdt_reset <= 1'b0;
    end else begin
      o_wdt_reset <= ovf_evt | svc_bad;
    end
  end

  // read clears status; a same-cycle event still lands
  always_comb begin
    stat_next = stat_reg;
    if (addr_valid && !i_hwrite && i_haddr[7:0] == wdt_pkg::ADDR_STATUS) begin
      stat_next = '0;
    end
    stat_next[wdt_pkg::ST_INTERVAL] = stat_next[wdt_pkg::ST_INTERVAL] | interval_evt;
    stat_next[wdt_pkg::ST_OVERFLOW] = stat_next[wdt_pkg::ST_OVERFLOW] | ovf_evt;
    stat_next[wdt_pkg::ST_SERVICE]  = stat_next[wdt_pkg::ST_SERVICE] | svc_bad;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      stat_reg <= wdt_pkg::STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mask_reg <= wdt_pkg::MASK_RESET;
    end else if (wr_pend_reg && wr_addr_reg == wdt_pkg::ADDR_MASK) begin
      mask_reg <= i_hwdata[wdt_pkg::STAT_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_next & mask_reg);
    end
  end

  always_comb begin
    rdata_next = 32'h00000000;
    unique case (i_haddr[7:0])
      wdt_pkg::ADDR_OPTION: rdata_next[7:0] = opt_reg;
      wdt_pkg::ADDR_STATUS: rdata_next[wdt_pkg::STAT_W-1:0] = stat_reg;
      wdt_pkg::ADDR_MASK:   rdata_next[wdt_pkg::STAT_W-1:0] = mask_reg;
      wdt_pkg::ADDR_COUNT:  rdata_next[wdt_pkg::CNT_W-1:0] = cnt_reg;
      default:              rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_hrdata <= 32'h00000000;
    end else if (addr_valid && !i_hwrite) begin
      o_hrdata <= rdata_next;
    end
  end

  ovf_period_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    loaded_reg && cfg.ovf_sel == 3'h4 |-> ovf_max == 17'h007FF)
    else $error("overflow period wrong for selection four");

  win_quarter_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    loaded_reg && cfg.standby_run && cfg.win_sel == wdt_pkg::WIN_75 |-> open_start == (period >> 2))
    else $error("75 percent window opens at wrong count");

  disabled_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    loaded_reg && !cfg.enable |=> cnt_reg == '0 && !o_wdt_reset)
    else $error("disabled watchdog moved");

  standby_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    loaded_reg && cfg.enable && !cfg.standby_run && pin_sync[1] && !svc_write |=> $stable(cnt_reg))
    else $error("counter ran in standby");

  window_full_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    loaded_reg && !cfg.standby_run |-> win_open)
    else $error("window not full with standby bit clear");

  good_service_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    svc_ok |=> cnt_reg == '0 && !o_wdt_reset)
    else $error("good service did not restart counter");

  bad_service_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    svc_write && !win_open |=> o_wdt_reset && stat_reg[wdt_pkg::ST_SERVICE])
    else $error("closed window write not punished");

  overflow_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    run && osc_rise && cnt_reg == ovf_max |=> o_wdt_reset && cnt_reg == '0)
    else $error("overflow did not reset");

  interval_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    run && osc_fall && cnt_reg == three_q |=> stat_reg[wdt_pkg::ST_INTERVAL])
    else $error("interval flag missed");

  cfg_frozen_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    loaded_reg |=> loaded_reg && $stable(opt_reg))
    else $error("configuration changed at run time");
endmodule

// *** testbench/windowed_watchdog_timer_tb.sv ***
`timescale 1ns/10ps
module windowed_watchdog_timer_tb;
  localparam logic [2:0] W   = wdt_pkg::HSIZE_WORD;
  localparam logic [7:0] OPT = wdt_pkg::ADDR_OPTION;
  localparam logic [7:0] SVC = wdt_pkg::ADDR_SERVICE;
  localparam logic [7:0] STA = wdt_pkg::ADDR_STATUS;
  localparam logic [7:0] MSK = wdt_pkg::ADDR_MASK;
  localparam logic [7:0] CNT = wdt_pkg::ADDR_COUNT;
  localparam int         TICK = 8;
  logic        i_clk_sys = 1'h0;
  logic        i_srst = 1'h1;
  logic        i_hsel = 1'h0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_hwrite = 1'h0;
  logic [2:0]  i_hsize = W;
  logic [31:0] i_hwdata = 32'h0;
  logic [7:0]  i_option_byte = 8'h0;
  logic        i_low_speed_osc_clock = 1'h0;
  logic        i_standby = 1'h0;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic        o_wdt_reset;
  logic        o_irq;
  logic [1:0]  div = 2'h0;
  logic [31:0] rd;
  int          seed = 90264;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          pulses = 0;
  int          exps [8] = '{6, 7, 8, 9, 11, 13, 14, 16};

  windowed_watchdog_timer u_dut (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_option_byte(i_option_byte),
    .i_low_speed_osc_clock(i_low_speed_osc_clock), .i_standby(i_standby), .o_wdt_reset(o_wdt_reset),
    .o_irq(o_irq));

  always #25 i_clk_sys = ~i_clk_sys;

  // slow clock free-runs at one eighth of the system clock, so a tick is eight cycles
  always @(posedge i_clk_sys) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      i_low_speed_osc_clock <= ~i_low_speed_osc_clock;
    end
    if (o_wdt_reset === 1'b1) begin
      pulses <= pulses + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    @(posedge i_clk_sys);
    i_hsel   <= 1'h1;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= wr;
    i_hsize  <= sz;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask

  // option byte held through the capture edges, hence the extra edge at the end
  task automatic restart(input logic [7:0] opt);
    @(posedge i_clk_sys);
    i_option_byte <= opt;
    i_srst        <= 1'h1;
    repeat (10) @(posedge i_clk_sys);
    i_srst <= 1'h0;
    repeat (4) @(posedge i_clk_sys);
  endtask

  task automatic wait_pulse(input int lim, output int n);
    n = 0;
    while (o_wdt_reset !== 1'b1 && n < lim) begin
      @(posedge i_clk_sys);
      n++;
    end
  endtask

  function automatic logic [7:0] mk(input int sel, input logic [1:0] win, input logic en, input logic sb);
    return {1'h0, win, en, sel[2:0], sb};
  endfunction

  initial begin
    int n;
    int p;
    int big;
    logic [1:0] w;
    logic [31:0] d;
    restart(mk(5, 2'h3, 1'h1, 1'h1));
    i_option_byte <= 8'h0;
    ahb(1'h1, OPT, 32'h0, W);
    ahb(1'h0, OPT, 32'h0, W);
    chk("option", {24'h0, mk(5, 2'h3, 1'h1, 1'h1)}, rd);
    ahb(1'h0, STA, 32'h0, W);
    chk("status", 32'h0, rd);
    ahb(1'h0, MSK, 32'h0, W);
    chk("mask", 32'h0, rd);
    ahb(1'h0, 8'hE0, 32'h0, W);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, o_hresp});
    restart(mk(0, 2'h3, 1'h0, 1'h1));
    wait_pulse(600, n);
    chk("off no reset", 32'd600, n);
    ahb(1'h0, CNT, 32'h0, W);
    chk("off count", 32'h0, rd);
    for (int s = 0; s < 5; s++) begin
      w = 2'($random(seed));
      big = (1 << exps[s]) * TICK;
      restart(mk(s, w, 1'h1, 1'($random(seed))));
      wait_pulse(big + 64, n);
      chk("overflow time", 32'h1, (n > big - 24 && n < big + 24));
      repeat (2) @(posedge i_clk_sys);
      ahb(1'h0, STA, 32'h0, W);
      chk("overflow status", 32'h3, rd);
      chk("masked irq", 32'h0, {31'h0, o_irq});
    end
    restart(mk(0, 2'h1, 1'h1, 1'h1));
    p = pulses;
    ahb(1'h1, SVC, 32'hAC, W);
    repeat (2) @(posedge i_clk_sys);
    chk("closed window", p + 1, pulses);
    ahb(1'h0, STA, 32'h0, W);
    chk("bad service", 32'h4, rd);
    n = 0;
    do begin
      ahb(1'h0, CNT, 32'h0, W);
      n++;
    end while (rd < 34 && n < 200);
    ahb(1'h1, SVC, 32'hAC, W);
    ahb(1'h0, CNT, 32'h0, W);
    chk("open service", p + 1, pulses);
    chk("cleared", 32'h1, rd < 2);
    // standby ignored here because the standby-run bit keeps counting
    restart(mk(0, 2'h3, 1'h1, 1'h1));
    i_standby <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      p = pulses;
      d = $random(seed);
      if (d[7:0] == 8'hAC) begin
        d[0] = 1'h1;
      end
      ahb(1'h1, SVC, (k == 0) ? d : 32'hAC, (k == 1) ? 3'h0 : W);
      repeat (2) @(posedge i_clk_sys);
      chk("service", p + (k < 2), pulses);
    end
    repeat (20 * TICK) @(posedge i_clk_sys);
    ahb(1'h0, CNT, 32'h0, W);
    chk("standby run", 32'h1, rd > 15);
    restart(mk(0, 2'h1, 1'h1, 1'h0));
    p = pulses;
    ahb(1'h1, SVC, 32'hAC, W);
    repeat (2) @(posedge i_clk_sys);
    chk("full window", p, pulses);
    ahb(1'h0, CNT, 32'h0, W);
    d = rd;
    repeat (20 * TICK) @(posedge i_clk_sys);
    ahb(1'h0, CNT, 32'h0, W);
    chk("stopped", d, rd);
    i_standby <= 1'h0;
    repeat (20 * TICK) @(posedge i_clk_sys);
    ahb(1'h0, CNT, 32'h0, W);
    chk("resumed", 32'h1, rd > d + 15);
    restart(mk(1, 2'h3, 1'h1, 1'h1));
    ahb(1'h1, MSK, 32'h1, W);
    n = 0;
    while (o_irq !== 1'b1 && n < 1100) begin
      @(posedge i_clk_sys);
      n++;
    end
    ahb(1'h0, CNT, 32'h0, W);
    chk("interval count", 32'h1, (rd == 96 || rd == 97));
    ahb(1'h0, STA, 32'h0, W);
    chk("interval status", 32'h1, rd);
    repeat (2) @(posedge i_clk_sys);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    // about 18 ticks in: open at 75 percent, still closed at 50 percent
    restart(mk(0, 2'h2, 1'h1, 1'h1));
    p = pulses;
    repeat (18 * TICK) @(posedge i_clk_sys);
    ahb(1'h1, SVC, 32'hAC, W);
    repeat (2) @(posedge i_clk_sys);
    chk("quarter window", p, pulses);
    end_sim();
  end
endmodule
